/* verif/test_test_skip_xor_literal_exec.sv */
/* self-checking bench for tsx_exec: queued expectations, output watcher.
   assumes tsx_exec and tsx_exec_chk are compiled before it. */
`timescale 1ns/1ps
module test_test_skip_xor_literal_exec;
   logic        i_clk_sys = 1'b0, i_reset_n = 1'b0;
   logic [15:0] i_instr = 16'h0000;
   logic        i_instr_next_two_word = 1'b0, i_ext_set_en = 1'b0;
   logic [3:0]  i_bank_select_reg = 4'h0;
   logic [7:0]  i_file_data = 8'h00, i_table_latch = 8'h00;
   logic        o_file_rd, o_file_indexed, o_flag_n, o_flag_z;
   logic        o_flag_upd, o_flush, o_nop_cycle, o_cycle_end, o_hold_we;
   logic [3:0]  o_file_bank;
   logic [7:0]  o_file_addr, o_working, o_hold_data, w = 8'h00;
   logic [21:0] o_table_pointer;
   logic [1:0]  o_phase;
   logic [7:0]  qw[$], qh[$], qf[$], qn[$];
   logic [21:0] qt[$], tp = 22'h000000;
   int          bad_count = 0, num_checks = 0, fc = 0;
   tsx_exec dut_u (.*);
   initial forever #2 i_clk_sys = ~i_clk_sys;
   task chk(input string nm, input logic [7:0] e, g);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task chk_ptr(input string nm, input logic [21:0] e, g);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
   endtask : chk_ptr
   task stop_test;
      if (bad_count == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : stop_test
   // word goes in at a q1 and stays until the last cycle it occupies
   task op(input logic [15:0] ins, input logic [7:0] dat, input logic two);
      int n;
      n = 1;
      do @(negedge i_clk_sys); while (o_phase !== 2'h3);
      @(posedge i_clk_sys);
      i_instr <= ins;
      i_file_data <= dat;
      i_table_latch <= dat;
      i_instr_next_two_word <= two;
      i_ext_set_en <= 1'($urandom);
      i_bank_select_reg <= 4'($urandom);
      if (ins[15:8] == 8'h0a) begin
         w = w ^ ins[7:0];
         qw.push_back(w);
         qn.push_back({6'h00, w[7], w == 8'h00});
      end
      if (ins[15:9] == 7'h33 && dat == 8'h00) begin
         n = two ? 3 : 2;
         qf.push_back(two ? 8'h08 : 8'h04);
      end
      if (ins[15:2] == 14'h0003) begin
         n = 2;
         qh.push_back(dat);
         if (ins[1:0] == 2'b01 || ins[1:0] == 2'b11)
            tp = tp + 22'h000001;
         else if (ins[1:0] == 2'b10)
            tp = tp - 22'h000001;
         qt.push_back(tp);
      end
      repeat (4 * n - 1) @(posedge i_clk_sys);
   endtask : op
   // negedge: every output has settled after the edge
   always @(negedge i_clk_sys) begin
      if (o_flag_upd === 1'b1) begin
         chk("working", qw.pop_front(), o_working);
         chk("flags", qn.pop_front(), {6'h00, o_flag_n, o_flag_z});
      end
      if (o_hold_we === 1'b1) begin
         chk("hold", qh.pop_front(), o_hold_data);
         chk_ptr("pointer", qt.pop_front(), o_table_pointer);
      end
      if (o_flush === 1'b1)
         fc++;
      else if (fc != 0) begin
         chk("flush", qf.pop_front(), 8'(fc));
         fc = 0;
      end
   end
   initial begin
      logic [7:0] f;
      void'($urandom(32'h78ae2ee8));
      repeat (10) @(posedge i_clk_sys);
      i_reset_n <= 1'b1;
      for (int i = 0; i < 8; i++)
         op({8'h0a, 8'($urandom)}, 8'h00, 1'b0);
      op({8'h0a, w}, 8'h00, 1'b0);
      for (int i = 0; i < 8; i++) begin
         f = i[0] ? 8'($urandom) : 8'h5f + 8'(i[1]);
         op({7'h33, i[0], f}, i[1] ? 8'h00 : 8'($urandom) | 8'h01, i[2]);
         op({8'h0a, 8'($urandom)}, 8'h00, 1'b0);
      end
      for (int m = 0; m < 4; m++)
         op(16'h000c | 16'(m), 8'($urandom), 1'b0);
      op(16'h0000, 8'h00, 1'b0);
      repeat (20) @(posedge i_clk_sys);
      // anything still queued never showed up at the outputs
      bad_count += qw.size() + qh.size() + qf.size() + qn.size() +
                   qt.size();
      stop_test();
   end
   initial begin
      repeat (5000) @(posedge i_clk_sys);
      bad_count++;
      stop_test();
   end
endmodule : test_test_skip_xor_literal_exec
bind tsx_exec tsx_exec_chk chk_u (.*);

/* verif/tsx_exec_chk.sv */
/* tsx_exec_chk: port assertions for tsx_exec.
   assumes a bind onto tsx_exec, one clock domain. */
`timescale 1ns/1ps
module tsx_exec_chk (
   input wire logic        i_clk_sys,
   input wire logic        i_reset_n,
   input wire logic [15:0] i_instr,
   input wire logic        i_instr_next_two_word,
   input wire logic        i_ext_set_en,
   input wire logic [3:0]  i_bank_select_reg,
   input wire logic [7:0]  i_file_data,
   input wire logic [7:0]  i_table_latch,
   input wire logic        o_file_rd,
   input wire logic [3:0]  o_file_bank,
   input wire logic [7:0]  o_file_addr,
   input wire logic        o_file_indexed,
   input wire logic [7:0]  o_working,
   input wire logic        o_flag_n,
   input wire logic        o_flag_z,
   input wire logic        o_flag_upd,
   input wire logic        o_flush,
   input wire logic        o_nop_cycle,
   input wire logic        o_cycle_end,
   input wire logic [7:0]  o_hold_data,
   input wire logic        o_hold_we,
   input wire logic [1:0]  o_phase
);
   logic       go;
   logic [3:0] tw_cnt;
   // second cycle of a table write takes no word either
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         tw_cnt <= 4'h0;
      end else if (go && i_instr[15:2] == 14'h0003) begin
         tw_cnt <= 4'h7;
      end else if (tw_cnt != 4'h0) begin
         tw_cnt <= tw_cnt - 4'h1;
      end
   end
   // a q1 that is not a skip cycle or a table-write second cycle takes a new word
   assign go = o_phase == 2'h0 && !o_flush && tw_cnt == 4'h0;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_reset_n);
   sequence s_tst;
      go && i_instr[15:9] == 7'h33;
   endsequence
   sequence s_zero(logic two);
      s_tst ##0 i_instr_next_two_word == two ##1 i_file_data == 8'h00;
   endsequence
   sequence s_xor;
      go && i_instr[15:8] == 8'h0a;
   endsequence
   xor_result_a: assert property (s_xor |-> ##4
      o_working == ($past(o_working, 4) ^ $past(i_instr[7:0], 4)))
      else $error("xor result wrong");
   xor_flags_a: assert property (s_xor |-> ##4 o_flag_upd &&
      o_flag_z == (o_working == 8'h00) && o_flag_n == o_working[7])
      else $error("xor flags wrong");
   file_addr_a: assert property (s_tst |=> o_file_rd &&
      o_file_addr == $past(i_instr[7:0]) && o_file_bank ==
      ($past(i_instr[8]) ? $past(i_bank_select_reg) :
      ($past(i_instr[7:0]) < 8'h60 ? 4'h0 : 4'hf)))
      else $error("file address wrong");
   index_mode_a: assert property (s_tst |=> o_file_indexed ==
      (!$past(i_instr[8]) && $past(i_ext_set_en) &&
      $past(i_instr[7:0]) <= 8'h5f)) else $error("index mode wrong");
   skip_one_a: assert property (s_zero(1'b0) |->
      ##3 o_flush [*4] ##1 !o_flush) else $error("single skip wrong");
   skip_two_a: assert property (s_zero(1'b1) |->
      ##3 o_flush [*8] ##1 !o_flush) else $error("double skip wrong");
   skip_idle_a: assert property (o_flush |-> $stable(o_working) &&
      !o_flag_upd && !o_hold_we && !o_file_rd) else $error("skip busy");
   tw_hold_a: assert property (go && i_instr[15:2] == 14'h0003 |->
      ##8 o_hold_we && o_hold_data == $past(i_table_latch, 3))
      else $error("holding write wrong");
   nop_skip_a: assert property (o_flush && o_phase != 2'h0 |->
      o_nop_cycle) else $error("skip cycle not idle");
   nop_quiet_a: assert property (!o_flush |-> !o_nop_cycle)
      else $error("idle flag outside skip");
   cycle_end_a: assert property (o_cycle_end ==
      (o_phase == 2'h0 && $past(o_phase) == 2'h3))
      else $error("cycle end misplaced");
endmodule : tsx_exec_chk

/* verilog/tsx_exec.sv */
/*
 * tsx_exec.sv: decode and execute for test-file-skip-if-zero,
 * xor-literal-into-working and the second cycle of table_write_op.
 * assumes an instruction word arrives valid at each cycle's q1 with
 * i_instr_next_two_word telling whether the prefetched word is 2-word;
 * file data returns combinationally on i_file_data in q2.
 */
`timescale 1ns/1ps
`include "tsx_map.svh"

module tsx_exec (
   input  wire logic        i_clk_sys,
   input  wire logic        i_reset_n,
   input  wire logic [15:0] i_instr,
   input  wire logic        i_instr_next_two_word,
   input  wire logic        i_ext_set_en,
   input  wire logic [3:0]  i_bank_select_reg,
   input  wire logic [7:0]  i_file_data,
   input  wire logic [7:0]  i_table_latch,
   output logic             o_file_rd,
   output logic [3:0]       o_file_bank,
   output logic [7:0]       o_file_addr,
   output logic             o_file_indexed,
   output logic [7:0]       o_working,
   output logic             o_flag_n,
   output logic             o_flag_z,
   output logic             o_flag_upd,
   output logic             o_flush,
   output logic             o_nop_cycle,
   output logic             o_cycle_end,
   output logic [7:0]       o_hold_data,
   output logic             o_hold_we,
   output logic [21:0]      o_table_pointer,
   output logic [1:0]       o_phase
);

   tsx_pkg::tsx_state_type s_q;
   tsx_pkg::tsx_state_type s_d;

   function automatic logic is_test_skip(input logic [15:0] ir);
      is_test_skip = (ir[15:9] == `TSX_OP_TEST_SKIP);
   endfunction : is_test_skip

   function automatic logic is_xor_lit(input logic [15:0] ir);
      is_xor_lit = (ir[15:8] == `TSX_OP_XOR_LIT);
   endfunction : is_xor_lit

   function automatic logic is_table_write(input logic [15:0] ir);
      is_table_write = (ir[15:2] == `TSX_OP_TABLE_WRITE_HI);
   endfunction : is_table_write

   always_comb begin
      s_d = s_q;
      s_d.flags.upd = 1'b0;
      s_d.hold_we   = 1'b0;
      s_d.freq.rd   = 1'b0;
      s_d.cyc_end   = 1'b0;
      case (s_q.phase)
         tsx_pkg::TSX_Q1: s_d.phase = tsx_pkg::TSX_Q2;
         tsx_pkg::TSX_Q2: s_d.phase = tsx_pkg::TSX_Q3;
         tsx_pkg::TSX_Q3: s_d.phase = tsx_pkg::TSX_Q4;
         default:         s_d.phase = tsx_pkg::TSX_Q1;
      endcase
      case (s_q.mode)
         tsx_pkg::TSX_ST_EXEC: begin
            case (s_q.phase)
               tsx_pkg::TSX_Q1: begin
                  s_d.ir  = i_instr;
                  s_d.nop = 1'b0;
                  if (is_test_skip(i_instr)) begin
                     s_d.freq.rd   = 1'b1;
                     s_d.freq.addr = i_instr[7:0];
                     // bank_select_reg only when a=1
                     s_d.freq.bank = i_instr[`TSX_ACC_BIT] ?
                        i_bank_select_reg :
                        ((i_instr[7:0] < `TSX_ACCESS_SPLIT) ? 4'h0 :
                         4'hf);
                     s_d.freq.indexed = !i_instr[`TSX_ACC_BIT] &&
                        i_ext_set_en &&
                        (i_instr[7:0] <= `TSX_IDX_LIMIT);
                     s_d.skip_two = i_instr_next_two_word;
                  end else if (is_table_write(i_instr)) begin
                     s_d.tw_mode = i_instr[1:0];
                     // pre-increment bumps before addressing
                     if (i_instr[1:0] == 2'b11) begin
                        s_d.tptr = s_q.tptr + 22'h000001;
                     end
                  end
               end
               tsx_pkg::TSX_Q2: begin
                  if (is_xor_lit(s_q.ir)) begin
                     s_d.alu = s_q.ir[7:0];
                  end else if (is_test_skip(s_q.ir)) begin
                     s_d.alu = i_file_data;
                  end
               end
               tsx_pkg::TSX_Q3: begin
                  if (is_xor_lit(s_q.ir)) begin
                     s_d.alu = s_q.w ^ s_q.alu;
                  end
               end
               default: begin
                  s_d.cyc_end = 1'b1;
                  if (is_xor_lit(s_q.ir)) begin
                     s_d.w         = s_q.alu;
                     s_d.flags.n   = s_q.alu[7];
                     s_d.flags.z   = (s_q.alu == 8'h00);
                     s_d.flags.upd = 1'b1;
                  end else if (is_test_skip(s_q.ir) &&
                               s_q.alu == 8'h00) begin
                     // flush, flags untouched
                     s_d.mode = tsx_pkg::TSX_ST_SKIP1;
                  end else if (is_table_write(s_q.ir)) begin
                     s_d.mode = tsx_pkg::TSX_ST_TABLE_WRITE2;
                  end
               end
            endcase
         end
         tsx_pkg::TSX_ST_SKIP1, tsx_pkg::TSX_ST_SKIP2: begin
            s_d.nop = 1'b1;
            if (s_q.phase == tsx_pkg::TSX_Q4) begin
               s_d.cyc_end = 1'b1;
               if (s_q.mode == tsx_pkg::TSX_ST_SKIP1 && s_q.skip_two) begin
                  s_d.mode = tsx_pkg::TSX_ST_SKIP2;
               end else begin
                  s_d.mode = tsx_pkg::TSX_ST_EXEC;
                  s_d.nop  = 1'b0;
               end
            end
         end
         tsx_pkg::TSX_ST_TABLE_WRITE2: begin
            s_d.nop = 1'b0;
            if (s_q.phase == tsx_pkg::TSX_Q2) begin
               s_d.tlat = i_table_latch;
            end else if (s_q.phase == tsx_pkg::TSX_Q4) begin
               s_d.hold    = s_q.tlat;
               s_d.hold_we = 1'b1;
               s_d.cyc_end = 1'b1;
               s_d.mode    = tsx_pkg::TSX_ST_EXEC;
               // post-increment or post-decrement: bump after the pointer was used
               if (s_q.tw_mode == 2'b01) begin
                  s_d.tptr = s_q.tptr + 22'h000001;
               end else if (s_q.tw_mode == 2'b10) begin
                  s_d.tptr = s_q.tptr - 22'h000001;
               end
            end
         end
         default: s_d.mode = tsx_pkg::TSX_ST_EXEC;
      endcase
      // registered so the flush output comes from a flop
      s_d.flush = (s_d.mode == tsx_pkg::TSX_ST_SKIP1) ||
                  (s_d.mode == tsx_pkg::TSX_ST_SKIP2);
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         s_q          <= '0;
         s_q.phase    <= tsx_pkg::TSX_Q1;
         s_q.mode     <= tsx_pkg::TSX_ST_EXEC;
         s_q.w        <= `TSX_W_RESET;
         s_q.tptr     <= `TSX_TP_RESET;
         s_q.hold     <= `TSX_HOLD_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_file_rd       = s_q.freq.rd;
   assign o_file_bank     = s_q.freq.bank;
   assign o_file_addr     = s_q.freq.addr;
   assign o_file_indexed  = s_q.freq.indexed;
   assign o_working       = s_q.w;
   assign o_flag_n        = s_q.flags.n;
   assign o_flag_z        = s_q.flags.z;
   assign o_flag_upd      = s_q.flags.upd;
   assign o_flush         = s_q.flush;
   assign o_nop_cycle     = s_q.nop;
   assign o_cycle_end     = s_q.cyc_end;
   assign o_hold_data     = s_q.hold;
   assign o_hold_we       = s_q.hold_we;
   assign o_table_pointer = s_q.tptr;
   assign o_phase         = s_q.phase;

endmodule : tsx_exec

/* verilog/tsx_map.svh */
/*
 * tsx_map.svh: opcode patterns, field positions, reset values and phase
 * counts for the test-skip / xor-literal / table-write execute block.
 * assumes it is included by name from design files; the package does not include it.
 */
`ifndef TSX_MAP_SVH
`define TSX_MAP_SVH

`define TSX_OP_TEST_SKIP      7'h33
`define TSX_OP_XOR_LIT        8'h0a
`define TSX_OP_TABLE_WRITE_HI 14'h0003
`define TSX_ACC_BIT           8
`define TSX_IDX_LIMIT         8'h5f
`define TSX_ACCESS_SPLIT      8'h60
`define TSX_W_RESET           8'h00
`define TSX_TP_RESET          22'h000000
`define TSX_Q_PHASES          4
`define TSX_HOLD_RESET        8'hff

`endif

/* verilog/tsx_pkg.sv */
/*
 * tsx_pkg.sv: types for the execute block.
 * needs nothing from tsx_map.svh; it uses none of its macros.
 */
package tsx_pkg;

   typedef enum logic [1:0] {
      TSX_Q1,
      TSX_Q2,
      TSX_Q3,
      TSX_Q4
   } tsx_phase_type;

   typedef enum logic [2:0] {
      TSX_ST_EXEC,
      TSX_ST_SKIP1,
      TSX_ST_SKIP2,
      TSX_ST_TABLE_WRITE2
   } tsx_mode_type;

   // file-register access request
   typedef struct packed {
      logic       rd;
      logic [3:0] bank;
      logic [7:0] addr;
      logic       indexed;
   } tsx_freq_type;

   // status flags touched by this block
   typedef struct packed {
      logic n;
      logic z;
      logic upd;
   } tsx_flag_type;

   typedef struct packed {
      tsx_phase_type  phase;
      tsx_mode_type   mode;
      logic [15:0]    ir;
      logic [7:0]     w;
      logic [7:0]     alu;
      logic [7:0]     tlat;
      logic [7:0]     hold;
      logic [21:0]    tptr;
      logic [1:0]     tw_mode;
      logic           skip_two;
      logic           hold_we;
      logic           nop;
      logic           cyc_end;
      logic           flush;
      tsx_freq_type   freq;
      tsx_flag_type   flags;
   } tsx_state_type;

endpackage : tsx_pkg
